// File: sdrv_ctrl.sv
// Purpose: Serial frame receiver with upper control and status fields
// Assumes: Serial clock far slower than CLK, sampled and edge-detected here
// Notes: Lower per-output fields and the second register pair are elsewhere
`timescale 1ns/1ps
module sdrv_ctrl
   import sdrv_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = sdrv_pkg::STARTUP_CYC_DEF
) (
   input wire logic CLK, // 125 MHz clock
   input wire logic RST_N, // Async reset, active low
   input wire sdrv_pkg::sdrv_spi_in_t SPI_IN, // Serial clock, select, data in
   input wire sdrv_pkg::sdrv_fault_in_t FAULT_IN, // Analog fault comparators
   output logic DOUT, // Serial data out
   output logic DOUT_OE, // Data out enable, high while driven
   output logic ACTIVE, // Device in active mode
   output logic OUT_ENABLE, // Drivers may be switched on
   output logic OC_DUTY_25, // Over-current recovery duty 25 percent
   output logic [3:0] MON_SEL, // One-hot current monitor source
   output logic STATUS_CLR // Pulse clearing all status words
);
   import sdrv_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk_d;
      logic cs_d;
      logic [4:0] cnt;
      logic [FRAME_BITS-1:0] rx;
      logic [FRAME_BITS-1:0] tx;
      logic dout_oe;
      logic active;
      logic clr_stat;
      logic duty;
      logic recdis;
      logic [1:0] mon;
      logic [3:0] mon_oh;
      logic ov;
      logic uv;
      logic thermal_shutdown_flag;
      logic tw;
      logic nr;
      logic [NR_W-1:0] nr_cnt;
      logic en;
   } sdrv_st_t;

   sdrv_st_t st_r;
   sdrv_st_t st_nxt;
   logic [SYNC_W-1:0] sync_q;
   sdrv_spi_in_t spi_s;
   sdrv_fault_in_t flt_s;

   // Select travels inverted so a freshly reset synchroniser reads as deselected
   sdrv_sync #(.W(SYNC_W)) u_sync (
      .CLK(CLK),
      .RST_N(RST_N),
      .D({SPI_IN.sclk, !SPI_IN.chip_select_low, SPI_IN.din, FAULT_IN}),
      .Q(sync_q)
   );

   assign spi_s = {sync_q[SYNC_W-1], !sync_q[SYNC_W-2], sync_q[SYNC_W-3]};
   assign flt_s = sync_q[3:0];

   // ----------------------------------------------------------------
   // Frame decode helpers
   // ----------------------------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic good;
   logic [FRAME_BITS-1:0] status_w;
   logic supply_bad;

   assign sclk_rise = spi_s.sclk && !st_r.sclk_d;
   assign sclk_fall = !spi_s.sclk && st_r.sclk_d;
   assign cs_fall = !spi_s.chip_select_low && st_r.cs_d;
   assign cs_rise = spi_s.chip_select_low && !st_r.cs_d;
   assign good = cs_rise && (st_r.cnt == FRAME_LEN) && !st_r.rx[B_SEL];
   assign supply_bad = flt_s.load_supply_ov || flt_s.load_supply_uv;

   always_comb
   begin
      status_w = '0;
      status_w[S_MARK] = 1'b1;
      status_w[S_OV] = st_r.ov;
      status_w[S_UV] = st_r.uv;
      status_w[S_TSD] = st_r.thermal_shutdown_flag;
      status_w[S_TW] = st_r.tw;
      status_w[S_NR] = st_r.nr;
      status_w[S_FAULT] = !(st_r.ov || st_r.uv || st_r.thermal_shutdown_flag || st_r.tw);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sclk_d = spi_s.sclk;
      st_nxt.cs_d = spi_s.chip_select_low;
      st_nxt.dout_oe = !spi_s.chip_select_low;
      st_nxt.clr_stat = 1'b0;
      if (cs_fall)
      begin
         st_nxt.cnt = '0;
         st_nxt.tx = status_w;
      end
      else if (!spi_s.chip_select_low)
      begin
         if (sclk_rise)
         begin
            st_nxt.rx = {spi_s.din, st_r.rx[FRAME_BITS-1:1]};
            if (st_r.cnt != CNT_SAT)
            begin
               st_nxt.cnt = st_r.cnt + 5'h1;
            end
            if (st_r.cnt == '0)
            begin
               st_nxt.tx = status_w;
            end
         end
         else if (sclk_fall && st_r.cnt != '0)
         begin
            st_nxt.tx = {1'b0, st_r.tx[FRAME_BITS-1:1]};
         end
      end
      if (good)
      begin
         st_nxt.active = st_r.rx[B_ENABLE];
         st_nxt.clr_stat = st_r.rx[B_CLEAR];
         st_nxt.duty = st_r.rx[B_DUTY];
         st_nxt.recdis = st_r.rx[B_RECDIS];
         st_nxt.mon = {st_r.rx[B_MON_HI], st_r.rx[B_MON_LO]};
         st_nxt.mon_oh = '0;
         case ({st_r.rx[B_MON_HI], st_r.rx[B_MON_LO]})
            2'h0: st_nxt.mon_oh[MON_EIGHT] = 1'b1;
            2'h2: st_nxt.mon_oh[MON_ONE] = 1'b1;
            2'h1: st_nxt.mon_oh[MON_FIVE] = 1'b1;
            2'h3: st_nxt.mon_oh[MON_FOUR] = 1'b1;
            default: st_nxt.mon_oh[MON_EIGHT] = 1'b1;
         endcase
         if (st_r.rx[B_ENABLE] && !st_r.active)
         begin
            st_nxt.nr = 1'b1;
            st_nxt.nr_cnt = NR_W'(STARTUP_CYC);
         end
      end
      // Status flags: clear at frame end or in standby, a pending set wins
      if (st_r.clr_stat || !st_r.active)
      begin
         st_nxt.ov = 1'b0;
         st_nxt.uv = 1'b0;
         st_nxt.thermal_shutdown_flag = 1'b0;
         st_nxt.tw = 1'b0;
      end
      if (flt_s.load_supply_ov) st_nxt.ov = 1'b1;
      if (flt_s.load_supply_uv) st_nxt.uv = 1'b1;
      if (flt_s.thermal_shutdown) st_nxt.thermal_shutdown_flag = 1'b1;
      if (flt_s.temperature_warning) st_nxt.tw = 1'b1;
      // Judge by the coming mode so a start frame keeps its timer
      if (!st_nxt.active)
      begin
         st_nxt.nr = 1'b0;
         st_nxt.nr_cnt = '0;
      end
      else if (st_r.nr)
      begin
         if (st_r.nr_cnt <= NR_W'(1))
         begin
            st_nxt.nr = 1'b0;
            st_nxt.nr_cnt = '0;
         end
         else
         begin
            st_nxt.nr_cnt = st_r.nr_cnt - NR_W'(1);
         end
      end
      // Warning takes no part in the enable
      st_nxt.en = st_r.active && !st_r.nr && !st_r.thermal_shutdown_flag && !supply_bad
         && !(st_r.recdis && (st_r.ov || st_r.uv));
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_r <= '0;
         st_r.sclk_d <= 1'b0;
         st_r.cs_d <= 1'b1;
         st_r.mon_oh <= 4'h8;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign DOUT = st_r.tx[0];
   assign DOUT_OE = st_r.dout_oe;
   assign ACTIVE = st_r.active;
   assign OUT_ENABLE = st_r.en;
   assign OC_DUTY_25 = st_r.duty;
   assign MON_SEL = st_r.mon_oh;
   assign STATUS_CLR = st_r.clr_stat;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_good_frame;
      good;
   endsequence

   sequence s_start_up;
      good && st_r.rx[B_ENABLE] && !st_r.active;
   endsequence

   a_frame_commit:
      assert property (s_good_frame |=> ACTIVE == $past(st_r.rx[B_ENABLE]))
      else $error("enable bit not committed");
   a_bad_frame:
      assert property (cs_rise && st_r.cnt != FRAME_LEN |=> $stable(ACTIVE) && !STATUS_CLR)
      else $error("bad frame changed control");
   a_clear_stat:
      assert property (s_good_frame ##0 st_r.rx[B_CLEAR] ##1 STATUS_CLR ##0
         !flt_s.thermal_shutdown |=> !st_r.thermal_shutdown_flag)
      else $error("thermal flag survived clear");
   a_duty_sel:
      assert property (s_good_frame |=> OC_DUTY_25 == $past(st_r.rx[B_DUTY]))
      else $error("duty select wrong");
   a_marker_bit:
      assert property (!spi_s.chip_select_low && st_r.cnt == FRAME_LEN && st_r.sclk_d |-> DOUT)
      else $error("marker bit not one");
   a_supply_off:
      assert property (supply_bad |=> !OUT_ENABLE ##0 (st_r.ov || st_r.uv))
      else $error("supply fault left outputs on");
   a_supply_recover:
      assert property (ACTIVE && !st_r.nr && !st_r.thermal_shutdown_flag && !supply_bad && !st_r.recdis
         |=> OUT_ENABLE)
      else $error("no automatic recovery");
   a_tsd_hold:
      assert property (st_r.thermal_shutdown_flag |=> !OUT_ENABLE)
      else $error("outputs on during shutdown");
   a_mon_eight:
      assert property (s_good_frame ##0 !st_r.rx[B_MON_HI] && !st_r.rx[B_MON_LO]
         |=> MON_SEL == 4'h8)
      else $error("monitor select wrong");
   a_not_ready:
      assert property (s_start_up |=> st_r.nr [*8] ##0 !OUT_ENABLE)
      else $error("not-ready not held");
endmodule

// File: sdrv_ctrl_bench.sv
// Purpose: Self-checking bench of the serial control and status block
// Assumes: Start-up timer shortened to 20 cycles
// Notes: Control bits 17:1 of ctl frames are random, bit 0 is zero, the upper fields are hand-picked
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sdrv_ctrl_bench;
   import sdrv_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   sdrv_spi_in_t spi_in;
   sdrv_fault_in_t fault_in = 4'h0;
   logic dout, dout_oe, active, out_enable, oc_duty_25, status_clr;
   logic [3:0] mon_sel;
   logic [23:0] rx;
   logic [31:0] rng = 32'h0000_0F00;
   int num_errors = 0;
   int n_compared = 0;
   int n_clr = 0;
   int k;

   always #4 CLK = ~CLK;
   always @(posedge CLK) if (status_clr === 1'b1) n_clr <= n_clr + 1;

   sdrv_ctrl #(.STARTUP_CYC(20)) i_dut (.CLK(CLK), .RST_N(RST_N), .SPI_IN(spi_in),
      .FAULT_IN(fault_in), .DOUT(dout), .DOUT_OE(dout_oe), .ACTIVE(active),
      .OUT_ENABLE(out_enable), .OC_DUTY_25(oc_duty_25), .MON_SEL(mon_sel),
      .STATUS_CLR(status_clr));
   sdrv_host i_host (.CLK(CLK), .DOUT(dout), .SPI_IN(spi_in));

   // ----------------------------------------------------------------
   // Expectations and drivers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [3:0] mon_exp(input logic [1:0] b);
      case (b)
         2'b00: return 4'h8;
         2'b10: return 4'h1;
         2'b01: return 4'h4;
         default: return 4'h2;
      endcase
   endfunction

   function automatic logic [23:0] stat_exp(input logic ov, uv, thermal_shutdown_flag, tw);
      return {1'b1, ov, uv, thermal_shutdown_flag, tw, 1'b0, 17'h0_0000, ~(ov | uv | thermal_shutdown_flag | tw)};
   endfunction

   task automatic ctl(input logic en, clr, duty, recdis, input logic [1:0] mon);
      rng = xs(rng);
      i_host.xfer(24, {en, clr, duty, recdis, mon, rng[17:1], 1'b0}, rx);
      repeat (4) @(posedge CLK);
   endtask

   task automatic fault(input logic [3:0] f, input int n);
      @(posedge CLK);
      fault_in <= f;
      repeat (n) @(posedge CLK);
   endtask

   // Raise one fault, release it, then clear the latched status
   task automatic fcase(input logic [3:0] f, input logic rd, input logic hold_off);
      int c0;
      ctl(1'b1, 1'b0, 1'b0, rd, 2'b00);
      `CHK(rx, stat_exp(1'b0, 1'b0, 1'b0, 1'b0))
      fault(f, 8);
      `CHK(out_enable, ~|f[3:1])
      fault(4'h0, 10);
      `CHK(out_enable, ~hold_off)
      c0 = n_clr;
      ctl(1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
      `CHK(rx, stat_exp(f[3], f[2], f[1], f[0]))
      `CHK(n_clr - c0, 1)
      `CHK(out_enable, 1'b1)
      $display("fault case %h done", f);
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      `CHK(active, 1'b0)
      `CHK(out_enable, 1'b0)
      `CHK(dout_oe, 1'b0)
      `CHK(mon_sel, 4'h8)
      $display("reset test done");
      for (k = 0; k < 4; k++)
      begin
         ctl(1'b1, 1'b0, k[0] ^ k[1], 1'b0, k[1:0]);
         `CHK(active, 1'b1)
         `CHK(oc_duty_25, k[0] ^ k[1])
         `CHK(mon_sel, mon_exp(k[1:0]))
         `CHK(rx, stat_exp(1'b0, 1'b0, 1'b0, 1'b0))
         if (k == 0)
            `CHK(out_enable, 1'b0)
         repeat (30) @(posedge CLK);
         `CHK(out_enable, 1'b1)
      end
      $display("control test done");
      for (k = 23; k < 26; k++)
      begin
         i_host.xfer(k, {23'h00_0000, k == 24}, rx);
         `CHK(active, 1'b1)
         `CHK(mon_sel, 4'h2)
      end
      $display("frame length test done");
      fcase(4'h8, 1'b0, 1'b0);
      fcase(4'h4, 1'b1, 1'b1);
      fcase(4'h2, 1'b0, 1'b1);
      fcase(4'h1, 1'b0, 1'b0);
      ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      `CHK(active, 1'b0)
      `CHK(out_enable, 1'b0)
      $display("standby test done");
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge CLK);
      num_errors++;
      test_done();
   end
endmodule

// File: sdrv_host.sv
// Purpose: Host model that drives serial frames into the control block
// Assumes: Serial clock period of 10 CLK cycles, idle low between frames
// Notes: Data out is sampled late in the high phase of each serial clock
`timescale 1ns/1ps
module sdrv_host (
   input wire logic CLK, // System clock
   input wire logic DOUT, // Serial data from the device
   output sdrv_pkg::sdrv_spi_in_t SPI_IN // Serial clock, select, data
);
   import sdrv_pkg::*;

   initial SPI_IN = 3'b010;

   task automatic wait_clk(input int n);
      repeat (n) @(posedge CLK);
   endtask

   // Sends n clock pulses, word bit 0 first, and returns the status word
   task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] r);
      r = 24'h00_0000;
      SPI_IN.chip_select_low <= 1'b0;
      wait_clk(5);
      for (int i = 0; i < n; i++)
      begin
         SPI_IN.din <= w[i % FRAME_BITS];
         wait_clk(5);
         SPI_IN.sclk <= 1'b1;
         wait_clk(5);
         if (i < FRAME_BITS)
            r[i] = DOUT;
         SPI_IN.sclk <= 1'b0;
      end
      wait_clk(5);
      SPI_IN.chip_select_low <= 1'b1;
      SPI_IN.din <= ~SPI_IN.din;
      wait_clk(8);
   endtask
endmodule

// File: sdrv_pkg.sv
// Purpose: Shared constants and carrier types of the serial control/status block
// Assumes: 24-bit frames, bit 0 first, serial clock idles low
// Notes: Only the upper control and status fields and bit 0 of each are modelled
// Behaviour
// - Control bit 23 selects active or standby
// - Commit only frames of exactly 24 clocks
// - Control bit 22 clears status at frame end
// - Control bit 21 picks 12% or 25% duty
// - Status bit 23 always reads one
// - Supply over/undervoltage sets flag, outputs off
// - Supply recovery re-enables outputs unless disabled
// - Thermal shutdown sets flag, outputs held off
// - Temperature warning never disables outputs
// - Bits 19:18 select monitored high-side output
// - Standby-to-active holds not-ready until timer ends
package sdrv_pkg;

   // ----------------------------------------------------------------
   // Frame and field layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] FRAME_LEN = 5'h18;
   localparam logic [4:0] CNT_SAT = 5'h19;
   localparam int B_SEL = 0;
   localparam int B_ENABLE = 23;
   localparam int B_CLEAR = 22;
   localparam int B_DUTY = 21;
   localparam int B_RECDIS = 20;
   localparam int B_MON_HI = 19;
   localparam int B_MON_LO = 18;
   localparam int S_MARK = 23;
   localparam int S_OV = 22;
   localparam int S_UV = 21;
   localparam int S_TSD = 20;
   localparam int S_TW = 19;
   localparam int S_NR = 18;
   localparam int S_FAULT = 0;

   // ----------------------------------------------------------------
   // Monitor select one-hot positions
   // ----------------------------------------------------------------
   localparam int MON_ONE = 0;
   localparam int MON_FOUR = 1;
   localparam int MON_FIVE = 2;
   localparam int MON_EIGHT = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int STARTUP_NS = 50000;
   localparam int STARTUP_CYC_DEF = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int NR_W = 16;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic chip_select_low;
      logic din;
   } sdrv_spi_in_t;

   typedef struct packed {
      logic load_supply_ov;
      logic load_supply_uv;
      logic thermal_shutdown;
      logic temperature_warning;
   } sdrv_fault_in_t;

   localparam int SYNC_W = 7;

endpackage

// File: sdrv_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module sdrv_sync #(
   parameter int W = 1
) (
   input wire logic CLK, // System clock
   input wire logic RST_N, // Async reset, active low
   input wire logic [W-1:0] D, // Asynchronous inputs
   output logic [W-1:0] Q // Synchronised outputs
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sdrv_sync_st_t;

   sdrv_sync_st_t st_r;
   sdrv_sync_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = D;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign Q = st_r.s2;
endmodule
